// ==== hw/dcs_top.sv ====
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_top import dcs_pkg::*; (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic [31:0]      reg_rdata,
	input  dcs_drive_t       drive_state,
	input  wire logic [15:0] app_status_half,
	output dcs_cmd_t         command,
	output logic             fault_reset_pulse,
	output logic [15:0]      app_control_half,
	output logic [15:0]      bus_speed_setpoint
);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [31:0] ctrl;
	logic [15:0] speed_ref;
	logic [3:0]  cfg;
	logic [15:0] held_ref;
	logic [31:0] status_word;

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire logic hit_ctrl   = dcs_hit(reg_addr, `DCS_OFS_CTRL);
	wire logic hit_status = dcs_hit(reg_addr, `DCS_OFS_STATUS);
	wire logic hit_speed  = dcs_hit(reg_addr, `DCS_OFS_SPEED);
	wire logic hit_cfg    = dcs_hit(reg_addr, `DCS_OFS_CFG);

	wire logic wr_ctrl  = reg_write & hit_ctrl;
	wire logic wr_speed = reg_write & hit_speed;
	wire logic wr_cfg   = reg_write & hit_cfg;

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	logic [31:0] next_ctrl;
	logic [15:0] next_speed_ref;
	logic [3:0]  next_cfg;
	logic [15:0] next_held_ref;
	logic [15:0] next_setpoint;
	logic        next_fault_reset;
	logic [31:0] next_rdata;
	logic [31:0] next_status;
	dcs_cmd_t    next_command;

	// Whole word stored; reserved bits never decoded
	assign next_ctrl      = wr_ctrl ? reg_wdata : ctrl;
	assign next_speed_ref = wr_speed ? reg_wdata[15:0] : speed_ref;
	assign next_cfg       = wr_cfg ? reg_wdata[3:0] : cfg;

	// Only a fresh 0 to 1 write of the reset bit counts
	assign next_fault_reset = wr_ctrl
		& reg_wdata[`DCS_CB_FRST]
		& ~ctrl[`DCS_CB_FRST];

	// Freeze holds the last accepted reference
	assign next_held_ref = next_command.freeze ? held_ref : speed_ref;

	// Zero request overrides the received reference
	assign next_setpoint = next_command.to_zero ? 16'h0000 : held_ref;

	// Read mux; control word is write only, reads zero
	assign next_rdata = !reg_read   ? 32'h0000_0000 :
		hit_status ? status_word :
		hit_speed  ? {16'h0000, speed_ref} :
		hit_cfg    ? {28'h000_0000, cfg} :
		32'h0000_0000;

	// ----------------------------------------
	// Decode and status assembly
	// ----------------------------------------
	dcs_ctrl_decode u_decode (
		.ctrl (ctrl),
		.cfg  (cfg),
		.cmd  (next_command)
	);

	dcs_status_build u_status (
		.drive    (drive_state),
		.app_half (app_status_half),
		.word     (next_status)
	);

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Software visible state
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ctrl      <= `DCS_RST_CTRL;
			speed_ref <= `DCS_RST_SPEED;
			cfg       <= `DCS_RST_CFG;
		end else begin
			ctrl      <= next_ctrl;
			speed_ref <= next_speed_ref;
			cfg       <= next_cfg;
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Drive outputs
	// ----------------------------------------
	// Registered so the drive sees glitch-free commands
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			command            <= '{stop_mode: DCS_STOP_RAMP, default: '0};
			fault_reset_pulse  <= 1'b0;
			app_control_half   <= 16'h0000;
			held_ref           <= `DCS_RST_SPEED;
			bus_speed_setpoint <= `DCS_RST_SPEED;
		end else begin
			command            <= next_command;
			fault_reset_pulse  <= next_fault_reset;
			app_control_half   <= ctrl[31:16];
			held_ref           <= next_held_ref;
			bus_speed_setpoint <= next_setpoint;
		end
	end

	// Status sampled each cycle; inputs share this clock
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			status_word <= 32'h0000_0000;
		end else begin
			status_word <= next_status;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_fault_reset_edge;
		@(posedge clock) disable iff (!nrst)
		(wr_ctrl && reg_wdata[`DCS_CB_FRST] && !ctrl[`DCS_CB_FRST])
		|=> fault_reset_pulse;
	endproperty
	a_fault_reset_edge: assert property (p_fault_reset_edge)
		else $error("fault reset edge not pulsed");

	property p_fault_reset_level;
		@(posedge clock) disable iff (!nrst)
		(wr_ctrl && ctrl[`DCS_CB_FRST]) |=> !fault_reset_pulse;
	endproperty
	a_fault_reset_level: assert property (p_fault_reset_level)
		else $error("fault reset fired on steady level");

	property p_fault_reset_single;
		@(posedge clock) disable iff (!nrst)
		fault_reset_pulse |=> !fault_reset_pulse;
	endproperty
	a_fault_reset_single: assert property (p_fault_reset_single)
		else $error("fault reset pulse longer than one cycle");

	property p_run_follows;
		@(posedge clock) disable iff (!nrst)
		wr_ctrl |-> ##2 (command.run == $past(reg_wdata[`DCS_CB_RUN], 2));
	endproperty
	a_run_follows: assert property (p_run_follows)
		else $error("run request does not follow control word");

	property p_dir_follows;
		@(posedge clock) disable iff (!nrst)
		wr_ctrl |-> ##2 (command.reverse == $past(reg_wdata[`DCS_CB_DIR], 2));
	endproperty
	a_dir_follows: assert property (p_dir_follows)
		else $error("direction does not follow control word");

	property p_coast_override;
		@(posedge clock) disable iff (!nrst)
		(ctrl[`DCS_CB_COAST] && !cfg[`DCS_CFG_VARIANT])
		|=> (command.stop_mode == DCS_STOP_COAST);
	endproperty
	a_coast_override: assert property (p_coast_override)
		else $error("coast override not applied");

	property p_ramp_override;
		@(posedge clock) disable iff (!nrst)
		(ctrl[`DCS_CB_RAMP] && !ctrl[`DCS_CB_COAST] && !cfg[`DCS_CFG_VARIANT])
		|=> (command.stop_mode == DCS_STOP_RAMP);
	endproperty
	a_ramp_override: assert property (p_ramp_override)
		else $error("ramp override not applied");

	property p_freeze_holds;
		@(posedge clock) disable iff (!nrst)
		next_command.freeze |=> $stable(held_ref);
	endproperty
	a_freeze_holds: assert property (p_freeze_holds)
		else $error("reference changed while frozen");

	property p_zero_setpoint;
		@(posedge clock) disable iff (!nrst)
		(ctrl[`DCS_CB_ZERO] && !cfg[`DCS_CFG_VARIANT])
		|=> (bus_speed_setpoint == 16'h0000);
	endproperty
	a_zero_setpoint: assert property (p_zero_setpoint)
		else $error("setpoint not forced to zero");

	property p_pass_through;
		@(posedge clock) disable iff (!nrst)
		(!next_command.freeze && !next_command.to_zero)[*2]
		|=> (bus_speed_setpoint == $past(speed_ref, 2));
	endproperty
	a_pass_through: assert property (p_pass_through)
		else $error("reference not passed through");

	property p_variant_din;
		@(posedge clock) disable iff (!nrst)
		cfg[`DCS_CFG_VARIANT]
		|=> (command.din == $past(ctrl[`DCS_CB_ZERO:`DCS_CB_COAST]))
		&& !command.quick_ramp && !command.to_zero;
	endproperty
	a_variant_din: assert property (p_variant_din)
		else $error("variant digital inputs wrong");

	property p_upper_half;
		@(posedge clock) disable iff (!nrst)
		wr_ctrl |-> ##2 (app_control_half == $past(reg_wdata[31:16], 2));
	endproperty
	a_upper_half: assert property (p_upper_half)
		else $error("upper control half not forwarded");

	property p_status_read;
		@(posedge clock) disable iff (!nrst)
		(reg_read && hit_status)
		|=> (reg_rdata == $past(status_word)) && (reg_rdata[15:8] == 8'h00);
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("status read data wrong");

	property p_status_bits;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (status_word[0] == $past(drive_state.ready))
		&& (status_word[1] == $past(drive_state.running))
		&& (status_word[3] == $past(drive_state.fault))
		&& (status_word[31:16] == $past(app_status_half));
	endproperty
	a_status_bits: assert property (p_status_bits)
		else $error("status bits do not track drive state");

	property p_at_ref;
		@(posedge clock) disable iff (!nrst)
		!drive_state.running |=> !status_word[5];
	endproperty
	a_at_ref: assert property (p_at_ref)
		else $error("at reference set while stopped");

	property p_rdata_idle;
		@(posedge clock) disable iff (!nrst)
		(!reg_read || hit_ctrl) |=> (reg_rdata == 32'h0000_0000);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero outside read answer");

	// Command fields follow the stored word one cycle later
	property p_quick_ramp;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (command.quick_ramp == ($past(ctrl[`DCS_CB_QRAMP]) && !$past(cfg[`DCS_CFG_VARIANT])));
	endproperty
	a_quick_ramp: assert property (p_quick_ramp)
		else $error("quick ramp does not follow control word");

	property p_bus_place;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (command.bus_control == ($past(ctrl[`DCS_CB_PLACE]) || $past(cfg[`DCS_CFG_PLACE])));
	endproperty
	a_bus_place: assert property (p_bus_place)
		else $error("control place override wrong");

	property p_bus_source;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (command.bus_reference == ($past(ctrl[`DCS_CB_REFSRC]) || $past(cfg[`DCS_CFG_REFSRC])));
	endproperty
	a_bus_source: assert property (p_bus_source)
		else $error("setpoint source override wrong");

	property p_jog;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (command.jog_one == $past(ctrl[`DCS_CB_JOG1]))
		&& (command.jog_two == $past(ctrl[`DCS_CB_JOG2]));
	endproperty
	a_jog: assert property (p_jog)
		else $error("jog requests do not follow control word");

	property p_quick_stop;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (command.quick_stop == $past(ctrl[`DCS_CB_QSTOP]));
	endproperty
	a_quick_stop: assert property (p_quick_stop)
		else $error("quick stop does not follow control word");

	// Digital inputs stay quiet outside the variant mode
	property p_din_clear;
		@(posedge clock) disable iff (!nrst)
		!cfg[`DCS_CFG_VARIANT] |=> (command.din == 5'h00);
	endproperty
	a_din_clear: assert property (p_din_clear)
		else $error("digital inputs active outside variant mode");

	// Remaining status flags track the drive one cycle later
	property p_direction_status;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (status_word[2] == $past(drive_state.ccw));
	endproperty
	a_direction_status: assert property (p_direction_status)
		else $error("rotation status bit wrong");

	property p_alarm_status;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (status_word[4] == $past(drive_state.alarm));
	endproperty
	a_alarm_status: assert property (p_alarm_status)
		else $error("alarm status bit wrong");

	property p_at_ref_set;
		@(posedge clock) disable iff (!nrst)
		(drive_state.running && drive_state.at_ref) |=> status_word[5];
	endproperty
	a_at_ref_set: assert property (p_at_ref_set)
		else $error("at reference not set while running at reference");

	property p_zero_speed_status;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (status_word[6] == $past(drive_state.zero_speed));
	endproperty
	a_zero_speed_status: assert property (p_zero_speed_status)
		else $error("zero speed status bit wrong");

	property p_magnetised_status;
		@(posedge clock) disable iff (!nrst)
		1'b1 |=> (status_word[7] == $past(drive_state.magnetised));
	endproperty
	a_magnetised_status: assert property (p_magnetised_status)
		else $error("magnetised status bit wrong");

endmodule : dcs_top

// ==== hw/dcs_map.svh ====
// Functional notes
// - Control word is 32 bits; low half fixed meaning, high half application defined.
// - Control bit 0 one requests run, zero requests stop.
// - Control bit 1 selects direction: zero forward, one reverse.
// - Only a rising edge of control bit 2 resets faults, alarms and infos.
// - Bit 3 forces coasting stop, bit 4 ramping stop; else configured mode.
// - Bit 5 selects a shorter deceleration ramp; clear means normal ramp.
// - While bit 6 is set, bus speed setpoint changes are ignored.
// - Bit 7 forces the bus setpoint to zero; else received reference used.
// - Bit 8 overrides control place to fieldbus; clear keeps configured place.
// - Bit 9 takes setpoint source from fieldbus; clear keeps configured source.
// - Bit 10 requests jog with reference one, bit 11 with reference two.
// - Bit 12 executes quick stop; clear means normal operation.
// - In variant mode bits 3 to 7 become five bus digital inputs.
// - Status word is 32 bits; reserved bits 8 to 15 read zero.
// - Status bit 0 shows drive ready to run.
// - Status bit 1 shows motor running.
// - Status bit 2 shows rotation: zero clockwise, one counterclockwise.
// - Status bit 3 shows any active fault, bit 4 any active alarm.
// - Status bit 5 set only while running at reference speed.
// - Status bit 6 set while motor is at zero speed.
// - Status bit 7 set once the motor is magnetised.
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DCS_OFS_CTRL   4'h0
`define DCS_OFS_STATUS 4'h4
`define DCS_OFS_SPEED  4'h8
`define DCS_OFS_CFG    4'hC

// ----------------------------------------
// Control word field positions
// ----------------------------------------
`define DCS_CB_RUN    0
`define DCS_CB_DIR    1
`define DCS_CB_FRST   2
`define DCS_CB_COAST  3
`define DCS_CB_RAMP   4
`define DCS_CB_QRAMP  5
`define DCS_CB_FREEZE 6
`define DCS_CB_ZERO   7
`define DCS_CB_PLACE  8
`define DCS_CB_REFSRC 9
`define DCS_CB_JOG1   10
`define DCS_CB_JOG2   11
`define DCS_CB_QSTOP  12

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define DCS_CFG_VARIANT 0
`define DCS_CFG_COAST   1
`define DCS_CFG_PLACE   2
`define DCS_CFG_REFSRC  3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DCS_RST_CTRL  32'h0000_0000
`define DCS_RST_SPEED 16'h0000
`define DCS_RST_CFG   4'h0

`endif

// ==== hw/dcs_pkg.sv ====
package dcs_pkg;

	// ----------------------------------------
	// Stop mode, one-hot
	// ----------------------------------------
	typedef enum logic [1:0] {
		DCS_STOP_RAMP  = 2'b01,
		DCS_STOP_COAST = 2'b10
	} dcs_stop_t;

	// Decoded drive commands
	typedef struct packed {
		logic      run;
		logic      reverse;
		dcs_stop_t stop_mode;
		logic      quick_ramp;
		logic      freeze;
		logic      to_zero;
		logic      bus_control;
		logic      bus_reference;
		logic      jog_one;
		logic      jog_two;
		logic      quick_stop;
		logic [4:0] din;
	} dcs_cmd_t;

	// Drive state feeding the status word
	typedef struct packed {
		logic ready;
		logic running;
		logic ccw;
		logic fault;
		logic alarm;
		logic at_ref;
		logic zero_speed;
		logic magnetised;
	} dcs_drive_t;

	// Register address match
	function automatic logic dcs_hit(input logic [3:0] a, input logic [3:0] o);
		return a == o;
	endfunction : dcs_hit

endpackage : dcs_pkg

// ==== hw/dcs_ctrl_decode.sv ====
`timescale 1ns/1ps
`include "dcs_map.svh"
module dcs_ctrl_decode import dcs_pkg::*; (
	input  wire logic [31:0] ctrl,
	input  wire logic [3:0]  cfg,
	output dcs_cmd_t         cmd
);
	wire logic variant  = cfg[`DCS_CFG_VARIANT];
	wire logic ov_coast = ~variant & ctrl[`DCS_CB_COAST];
	wire logic ov_ramp  = ~variant & ctrl[`DCS_CB_RAMP];
	wire dcs_stop_t cfg_stop = cfg[`DCS_CFG_COAST] ? DCS_STOP_COAST : DCS_STOP_RAMP;

	// ----------------------------------------
	// Fixed half decode; bits 13..15 ignored
	// ----------------------------------------
	assign cmd.run        = ctrl[`DCS_CB_RUN];
	assign cmd.reverse    = ctrl[`DCS_CB_DIR];
	// Coasting wins if both overrides are set
	assign cmd.stop_mode  = ov_coast ? DCS_STOP_COAST : (ov_ramp ? DCS_STOP_RAMP : cfg_stop);
	assign cmd.quick_ramp = ~variant & ctrl[`DCS_CB_QRAMP];
	assign cmd.freeze     = ~variant & ctrl[`DCS_CB_FREEZE];
	assign cmd.to_zero    = ~variant & ctrl[`DCS_CB_ZERO];
	assign cmd.bus_control   = ctrl[`DCS_CB_PLACE] | cfg[`DCS_CFG_PLACE];
	assign cmd.bus_reference = ctrl[`DCS_CB_REFSRC] | cfg[`DCS_CFG_REFSRC];
	assign cmd.jog_one    = ctrl[`DCS_CB_JOG1];
	assign cmd.jog_two    = ctrl[`DCS_CB_JOG2];
	assign cmd.quick_stop = ctrl[`DCS_CB_QSTOP];
	// Variant drive reuses bits 3..7 as inputs
	assign cmd.din = variant ? ctrl[`DCS_CB_ZERO:`DCS_CB_COAST] : 5'h00;

endmodule : dcs_ctrl_decode

// ==== hw/dcs_status_build.sv ====
`timescale 1ns/1ps
module dcs_status_build import dcs_pkg::*; (
	input  dcs_drive_t        drive,
	input  wire logic [15:0]  app_half,
	output logic [31:0]       word
);
	// Fixed half, high bit first; 8..15 reserved
	assign word = {app_half,
		8'h00,
		drive.magnetised,
		drive.zero_speed,
		drive.running & drive.at_ref,
		drive.alarm,
		drive.fault,
		drive.ccw,
		drive.running,
		drive.ready};

endmodule : dcs_status_build

// ==== verification/dcs_bus_master.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Fieldbus master stand-in on the register port
// ----------------------------------------
module dcs_bus_master (
	input  wire logic        clock,
	output logic [3:0]       reg_addr,
	output logic [31:0]      reg_wdata,
	output logic             reg_write,
	output logic             reg_read,
	input  wire logic [31:0] reg_rdata
);
	// Idle bus at time zero
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 32'h0000_0000;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end

	// One-cycle write; data inverted after release so stale data never looks valid
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= (a == 4'h0) ? (d & 32'hFFFF_1FFF) : d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		reg_wdata <= ~reg_wdata;
	endtask : wr

	// One-cycle read; data taken in the following cycle only
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : dcs_bus_master

// ==== verification/dcs_top_tb.sv ====
`timescale 1ns/1ps
module dcs_top_tb;
	import dcs_pkg::*;
	logic        clock;
	logic        nrst;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_write;
	logic        reg_read;
	logic [31:0] reg_rdata;
	dcs_drive_t  drive_state;
	logic [15:0] app_status_half;
	dcs_cmd_t    command;
	logic        fault_reset_pulse;
	logic [15:0] app_control_half;
	logic [15:0] bus_speed_setpoint;
	int          bad_count;
	int          samples_checked;
	logic [31:0] d;

	// ----------------------------------------
	// Design and master
	// ----------------------------------------
	dcs_top u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .drive_state(drive_state),
		.app_status_half(app_status_half), .command(command), .fault_reset_pulse(fault_reset_pulse),
		.app_control_half(app_control_half), .bus_speed_setpoint(bus_speed_setpoint));
	dcs_bus_master u_master (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

	// 100 MHz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : settle

	// Expected decode; variant mode turns bits 3..7 into digital inputs
	function automatic dcs_cmd_t exp_cmd(input logic [31:0] w, input logic [3:0] c);
		dcs_cmd_t e;
		e = '0;
		e.run = w[0];
		e.reverse = w[1];
		e.stop_mode = c[1] ? DCS_STOP_COAST : DCS_STOP_RAMP;
		if (!c[0] && w[3]) e.stop_mode = DCS_STOP_COAST;
		else if (!c[0] && w[4]) e.stop_mode = DCS_STOP_RAMP;
		e.quick_ramp = w[5] & ~c[0];
		e.freeze = w[6] & ~c[0];
		e.to_zero = w[7] & ~c[0];
		e.bus_control = w[8] | c[2];
		e.bus_reference = w[9] | c[3];
		e.jog_one = w[10];
		e.jog_two = w[11];
		e.quick_stop = w[12];
		e.din = c[0] ? w[7:3] : 5'h00;
		return e;
	endfunction : exp_cmd

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		settle(0);
		chk("command", 32'(command), 32'(exp_cmd(32'h0000_0000, 4'h0)));
		chk("pulse", 32'(fault_reset_pulse), 32'h0000_0000);
		chk("app ctrl", 32'(app_control_half), 32'h0000_0000);
		chk("setpoint", 32'(bus_speed_setpoint), 32'h0000_0000);
		u_master.rd(4'hC, d);
		chk("cfg", d, 32'h0000_0000);
	endtask : t_reset

	// Every command bit under four configurations, plus coast-beats-ramp
	task automatic t_control;
		logic [3:0]  cfgs [4];
		logic [31:0] w;
		cfgs = '{4'h0, 4'h2, 4'h1, 4'hC};
		foreach (cfgs[k]) begin
			u_master.wr(4'hC, {28'h0000000, cfgs[k]});
			for (int b = 0; b <= 13; b++) begin
				w = (b == 13) ? 32'h8001_0018 : {16'hA5C3 ^ 16'(b), 16'h0001 << b};
				u_master.wr(4'h0, w);
				settle(1);
				chk("command", 32'(command), 32'(exp_cmd(w, cfgs[k])));
				chk("app ctrl", 32'(app_control_half), 32'(w[31:16]));
			end
		end
		u_master.wr(4'hC, 32'h0000_0000);
	endtask : t_control

	// Pulse only on a rising edge across writes, one cycle long
	task automatic t_fault;
		logic [31:0] seq [5];
		logic        exp [5];
		seq = '{32'h0, 32'h4, 32'h4, 32'h0, 32'h5};
		exp = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
		foreach (seq[k]) begin
			u_master.wr(4'h0, seq[k]);
			settle(0);
			chk("pulse", 32'(fault_reset_pulse), 32'(exp[k]));
			settle(1);
			chk("pulse end", 32'(fault_reset_pulse), 32'h0000_0000);
		end
	endtask : t_fault

	// Setpoint pass, freeze and force to zero
	task automatic t_speed;
		u_master.wr(4'h0, 32'h0);
		u_master.wr(4'h8, 32'h0000_1234);
		settle(2);
		chk("setpoint", 32'(bus_speed_setpoint), 32'h0000_1234);
		u_master.wr(4'h0, 32'h0000_0040);
		u_master.wr(4'h8, 32'h0000_5678);
		settle(3);
		chk("frozen", 32'(bus_speed_setpoint), 32'h0000_1234);
		u_master.rd(4'h8, d);
		chk("speed reg", d, 32'h0000_5678);
		u_master.wr(4'h0, 32'h0000_0000);
		settle(3);
		chk("thawed", 32'(bus_speed_setpoint), 32'h0000_5678);
		u_master.wr(4'h0, 32'h0000_0080);
		settle(2);
		chk("zeroed", 32'(bus_speed_setpoint), 32'h0000_0000);
		u_master.wr(4'h0, 32'h0000_0000);
		settle(3);
		chk("restored", 32'(bus_speed_setpoint), 32'h0000_5678);
	endtask : t_speed

	// Each drive flag alone, then running at reference; status write ignored
	task automatic t_status;
		dcs_drive_t s;
		logic [7:0] lo;
		u_master.wr(4'h4, 32'hFFFF_FFFF);
		for (int i = 0; i <= 8; i++) begin
			s = (i < 8) ? dcs_drive_t'(8'h01 << i) : dcs_drive_t'(8'h44);
			@(posedge clock);
			drive_state <= s;
			app_status_half <= 16'hC3A0 ^ 16'(i);
			repeat (2) @(posedge clock);
			u_master.rd(4'h4, d);
			lo = {s.magnetised, s.zero_speed, s.running & s.at_ref, s.alarm, s.fault, s.ccw, s.running, s.ready};
			chk("status", d, {16'hC3A0 ^ 16'(i), 8'h00, lo});
			settle(1);
			chk("rdata idle", reg_rdata, 32'h0000_0000);
		end
		u_master.rd(4'h0, d);
		chk("ctrl read", d, 32'h0000_0000);
		u_master.wr(4'hC, 32'hFFFF_FFFF);
		u_master.wr(4'h6, 32'h0000_0000);
		u_master.rd(4'h6, d);
		chk("unmapped", d, 32'h0000_0000);
		u_master.rd(4'hC, d);
		chk("cfg", d, 32'h0000_000F);
	endtask : t_status

	// ----------------------------------------
	// Verdict
	// ----------------------------------------
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// Hang guard, well above the longest expected run
	initial begin
		repeat (20000) @(posedge clock);
		bad_count++;
		conclude;
	end

	// Main sequence
	initial begin
		bad_count = 0;
		samples_checked = 0;
		nrst = 1'b0;
		drive_state = '0;
		app_status_half = 16'h0000;
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		t_reset;
		t_control;
		t_fault;
		t_speed;
		t_status;
		conclude;
	end
endmodule : dcs_top_tb
